/* hdl/efs_pkg.sv */
// Constants, register map and state encoding shared by the fault and status logic
package efs_pkg;
  // Clock and the fixed restart deglitch after a fast trip
  localparam int CLK_PERIOD_NS = 5;
  localparam int TRIP_DEGLITCH_NS = 30000;
  localparam int TRIP_CYC_DFLT = (TRIP_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width for all programmable delays
  localparam int CW_DFLT = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BLANK = 8'h04;
  localparam logic [7:0] ADDR_RETRY = 8'h08;
  localparam logic [7:0] ADDR_PGA = 8'h0c;
  localparam logic [7:0] ADDR_PGD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h20;

  // Reset values of the delay registers, in clock cycles
  localparam logic [15:0] BLANK_RST = 16'h0100;
  localparam logic [15:0] RETRY_RST = 16'h0400;
  localparam logic [15:0] PGA_RST = 16'h0080;
  localparam logic [15:0] PGD_RST = 16'h0040;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // Sticky event bits
  localparam int IRQ_W = 5;
  localparam int IRQ_LATCH = 0;
  localparam int IRQ_FLAG = 1;
  localparam int IRQ_PG = 2;
  localparam int IRQ_SGFALL = 3;
  localparam int IRQ_TRIP = 4;

  // Positions in the synchronised input vector
  localparam int NIN = 16;
  localparam int IN_VIN = 0;
  localparam int IN_ENUV = 1;
  localparam int IN_ENSD = 2;
  localparam int IN_OVERVOLTAGE_LOCKOUT = 3;
  localparam int IN_OC = 4;
  localparam int IN_FT = 5;
  localparam int IN_ILMO = 6;
  localparam int IN_ILMS = 7;
  localparam int IN_HOT = 8;
  localparam int IN_COOL = 9;
  localparam int IN_PGR = 10;
  localparam int IN_PGF = 11;
  localparam int IN_GATE = 12;
  localparam int IN_FPIN = 13;
  localparam int IN_PGPIN = 14;
  localparam int IN_SGPIN = 15;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_INRUSH = 3'b001,
    ST_ON = 3'b010,
    ST_TRIP = 3'b011,
    ST_LATCH = 3'b100,
    ST_RETRY = 3'b101
  } efs_state_type;
endpackage : efs_pkg

/* hdl/efs_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels
module efs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : efs_sync

/* hdl/efs_delay.sv */
// Restartable delay counter: done once its trigger has held for limit cycles
module efs_delay #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Trigger and length
  input wire logic trig_i,
  input wire logic [CW-1:0] limit_i,
  output logic done_o
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire sat = &cnt_r;

  // Dropping the trigger restarts the count from zero
  assign cnt_nxt = !trig_i ? '0 : (sat ? cnt_r : cnt_r + {{(CW-1){1'b0}}, 1'b1});
  assign done_o = trig_i && (cnt_r >= limit_i);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : efs_delay

/* hdl/efs_fault_status.sv */
// Fault supervision, power path sequencing and status pins of the power switch, with APB registers

// Function
// - Fault-output variant drives an active-low fault flag for selected faults.
// - Persistent forward overcurrent limits current; flag low after blanking, not latched.
// - Output short trips switch off fast, resumes current limited, no latch, no flag.
// - Latched fault clears only on supply loss, enable below shutdown threshold or, in the auto-retry variant, retry timer expiry.
// - Those clearing events also reset the retry delay timer.
// - Enable dipping below undervoltage but not shutdown does not clear a latched fault.
// - Auto-retry variant restarts the power path when the retry timer expires.
// - Power-good variant drives an active-high open-drain power-good output.
// - Power-good low after power-up; asserts after deglitch once inrush done and sense high.
// - Power-good drops after deglitch on sense low or a sense-pin fault; at once on invalid supply or thermal latch.
// - Short, transient or persistent overcurrent leave power-good following the sense input.
// - Supply-good variant asserts supply-good when input valid and inrush finished.
// - Supply-good stays low through inrush, rises at full gate overdrive.
// - Supply-good falls only on invalid supply, never on load faults.
// - After thermal shutdown auto-retry waits for cooling, then retry delay, if enabled.
// - After thermal overload latch-off stays off until power cycle or re-enable.
module efs_fault_status #(
  parameter bit AUTO_RETRY = 1'b1,
  parameter bit PG_VARIANT = 1'b0,
  parameter int CW = efs_pkg::CW_DFLT,
  parameter int TRIP_CYC = efs_pkg::TRIP_CYC_DFLT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Analog comparator and sense inputs
  input wire logic vin_present_i,
  input wire logic enable_undervoltage_in_i,
  input wire logic enable_above_shutdown_i,
  input wire logic overvoltage_lockout_i,
  input wire logic overcurrent_i,
  input wire logic fast_trip_i,
  input wire logic current_sense_pin_open_i,
  input wire logic current_sense_pin_short_i,
  input wire logic thermal_shutdown_limit_i,
  input wire logic thermal_cooled_i,
  input wire logic good_threshold_sense_rise_i,
  input wire logic good_threshold_sense_fall_i,
  input wire logic gate_full_overdrive_i,
  // Power switch control
  output logic power_switch_on_o,
  output logic current_limit_o,
  // Open-drain status pins
  input wire logic fault_flag_n_i,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_o,
  input wire logic power_good_out_i,
  output logic power_good_out_o,
  output logic power_good_out_oe_o,
  input wire logic supply_valid_out_i,
  output logic supply_valid_out_o,
  output logic supply_valid_out_oe_o,
  // Interrupt
  output logic irq_o
);
  if (CW < 8 || CW > 32 || TRIP_CYC < 1 || TRIP_CYC >= (64'd1 << CW)) begin : g_bad_param
    $error("efs_fault_status: counter width cannot hold the delays");
  end

  // Input synchronisation
  logic [efs_pkg::NIN-1:0] raw_in;
  logic [efs_pkg::NIN-1:0] s_in;
  assign raw_in = {supply_valid_out_i, power_good_out_i, fault_flag_n_i, gate_full_overdrive_i,
                   good_threshold_sense_fall_i, good_threshold_sense_rise_i, thermal_cooled_i,
                   thermal_shutdown_limit_i, current_sense_pin_short_i, current_sense_pin_open_i,
                   fast_trip_i, overcurrent_i, overvoltage_lockout_i, enable_above_shutdown_i,
                   enable_undervoltage_in_i, vin_present_i};

  efs_sync #(.W(efs_pkg::NIN)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i(raw_in),
    .sync_o(s_in)
  );

  wire supply_ok = s_in[efs_pkg::IN_VIN] && s_in[efs_pkg::IN_ENUV] && !s_in[efs_pkg::IN_OVERVOLTAGE_LOCKOUT];
  wire clr_evt = !s_in[efs_pkg::IN_VIN] || !s_in[efs_pkg::IN_ENSD];

  // Registers
  logic [31:0] ctrl_r;
  logic [CW-1:0] blank_r;
  logic [CW-1:0] retry_r;
  logic [CW-1:0] pga_r;
  logic [CW-1:0] pgd_r;
  logic [efs_pkg::IRQ_W-1:0] irq_sts_r;
  logic [efs_pkg::IRQ_W-1:0] irq_en_r;
  efs_pkg::efs_state_type st_r;
  efs_pkg::efs_state_type st_nxt;
  logic thermal_r;
  logic flag_r;
  logic pg_r;
  logic sg_r;

  // Delay counters: blanking for three sensed faults, two deglitches, retry and trip
  localparam int ND = 7;
  localparam int D_OC = 0;
  localparam int D_ILMO = 1;
  localparam int D_ILMS = 2;
  localparam int D_PGA = 3;
  localparam int D_PGD = 4;
  localparam int D_RETRY = 5;
  localparam int D_TRIP = 6;
  logic [ND-1:0] d_trig;
  logic [ND-1:0] d_done;
  logic [CW-1:0] d_lim [ND];

  wire running = (st_r == efs_pkg::ST_ON);
  wire conducting = (st_r == efs_pkg::ST_INRUSH) || running;
  wire latched = (st_r == efs_pkg::ST_LATCH) || (st_r == efs_pkg::ST_RETRY);
  // Overcurrent and short are not power-good faults, so they are kept out of this term
  wire pg_fault = latched || !supply_ok || d_done[D_ILMO];
  wire pg_hard = !supply_ok || thermal_r;

  assign d_trig[D_OC] = running && s_in[efs_pkg::IN_OC];
  assign d_trig[D_ILMO] = supply_ok && s_in[efs_pkg::IN_ILMO];
  assign d_trig[D_ILMS] = conducting && s_in[efs_pkg::IN_ILMS];
  assign d_trig[D_PGA] = !pg_r && (running || st_r == efs_pkg::ST_TRIP) && s_in[efs_pkg::IN_PGR] && !pg_fault;
  assign d_trig[D_PGD] = pg_r && (s_in[efs_pkg::IN_PGF] || pg_fault);
  assign d_trig[D_RETRY] = (st_r == efs_pkg::ST_RETRY) && !clr_evt;
  assign d_trig[D_TRIP] = (st_r == efs_pkg::ST_TRIP);
  assign d_lim[D_OC] = blank_r;
  assign d_lim[D_ILMO] = blank_r;
  assign d_lim[D_ILMS] = blank_r;
  assign d_lim[D_PGA] = pga_r;
  assign d_lim[D_PGD] = pgd_r;
  assign d_lim[D_RETRY] = retry_r;
  assign d_lim[D_TRIP] = CW'(TRIP_CYC);

  for (genvar g = 0; g < ND; g++) begin : g_dly
    efs_delay #(.CW(CW)) u_dly (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .trig_i(d_trig[g]),
      .limit_i(d_lim[g]),
      .done_o(d_done[g])
    );
  end

  // Power path sequencing
  wire hot = s_in[efs_pkg::IN_HOT];
  wire go_latch = conducting && (hot || d_done[D_ILMS]);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      efs_pkg::ST_OFF: begin
        if (supply_ok && ctrl_r[efs_pkg::CTRL_EN_BIT] && !s_in[efs_pkg::IN_ILMO] && !hot) begin
          st_nxt = efs_pkg::ST_INRUSH;
        end
      end
      efs_pkg::ST_INRUSH, efs_pkg::ST_ON: begin
        if (!supply_ok || !ctrl_r[efs_pkg::CTRL_EN_BIT] || d_done[D_ILMO]) begin
          st_nxt = efs_pkg::ST_OFF;
        end else if (go_latch) begin
          st_nxt = efs_pkg::ST_LATCH;
        end else if (running && s_in[efs_pkg::IN_FT]) begin
          st_nxt = efs_pkg::ST_TRIP;
        end else if (st_r == efs_pkg::ST_INRUSH && s_in[efs_pkg::IN_GATE]) begin
          st_nxt = efs_pkg::ST_ON;
        end
      end
      efs_pkg::ST_TRIP: begin
        if (!supply_ok) begin
          st_nxt = efs_pkg::ST_OFF;
        end else if (hot) begin
          st_nxt = efs_pkg::ST_LATCH;
        end else if (d_done[D_TRIP]) begin
          st_nxt = efs_pkg::ST_ON;
        end
      end
      efs_pkg::ST_LATCH: begin
        if (clr_evt) begin
          st_nxt = efs_pkg::ST_OFF;
        end else if (AUTO_RETRY && (!thermal_r || (!hot && s_in[efs_pkg::IN_COOL]))) begin
          st_nxt = efs_pkg::ST_RETRY;
        end
      end
      efs_pkg::ST_RETRY: begin
        if (clr_evt || d_done[D_RETRY]) begin
          st_nxt = efs_pkg::ST_OFF;
        end
      end
      default: st_nxt = efs_pkg::ST_OFF;
    endcase
  end

  // Status outputs; a low-voltage enable dip alone never leaves a latched state
  wire flag_nxt = latched || d_done[D_OC] || d_done[D_ILMO] || d_done[D_ILMS];
  wire pg_nxt = pg_r ? !(d_done[D_PGD] || pg_hard) : d_done[D_PGA];
  wire sg_nxt = supply_ok && (sg_r || (st_r == efs_pkg::ST_INRUSH && s_in[efs_pkg::IN_GATE]));
  wire thermal_nxt = (st_nxt == efs_pkg::ST_LATCH && !latched) ? hot : (latched && thermal_r);
  wire climit_nxt = conducting && s_in[efs_pkg::IN_OC];

  // APB decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  wire setup = psel_i && !penable_i;
  wire wr_en = psel_i && penable_i && pwrite_i && pready_o;
  wire a_ctrl = hit(paddr_i, efs_pkg::ADDR_CTRL);
  wire a_blank = hit(paddr_i, efs_pkg::ADDR_BLANK);
  wire a_retry = hit(paddr_i, efs_pkg::ADDR_RETRY);
  wire a_pga = hit(paddr_i, efs_pkg::ADDR_PGA);
  wire a_pgd = hit(paddr_i, efs_pkg::ADDR_PGD);
  wire a_sts = hit(paddr_i, efs_pkg::ADDR_STATUS);
  wire a_isr = hit(paddr_i, efs_pkg::ADDR_IRQ_STS);
  wire a_icl = hit(paddr_i, efs_pkg::ADDR_IRQ_CLR);
  wire a_ien = hit(paddr_i, efs_pkg::ADDR_IRQ_EN);
  wire mapped = a_ctrl || a_blank || a_retry || a_pga || a_pgd || a_sts || a_isr || a_icl || a_ien;
  // Status and event registers are read-only; writing them is an error
  wire bad_acc = !mapped || (pwrite_i && (a_sts || a_isr));

  wire [31:0] status_w = {20'h0, s_in[efs_pkg::IN_SGPIN], s_in[efs_pkg::IN_PGPIN], s_in[efs_pkg::IN_FPIN],
                          sg_r, pg_r, flag_r, thermal_r, current_limit_o, 1'b0, st_r};
  wire [31:0] rd_mux = a_ctrl ? ctrl_r :
                       a_blank ? 32'(blank_r) :
                       a_retry ? 32'(retry_r) :
                       a_pga ? 32'(pga_r) :
                       a_pgd ? 32'(pgd_r) :
                       a_sts ? status_w :
                       a_isr ? 32'(irq_sts_r) :
                       a_ien ? 32'(irq_en_r) : 32'h0;

  // Events; a new event in the clearing cycle wins over the clear
  wire [efs_pkg::IRQ_W-1:0] evt = {st_nxt == efs_pkg::ST_TRIP && st_r != efs_pkg::ST_TRIP,
                                    sg_r && !sg_nxt, pg_r != pg_nxt, flag_nxt && !flag_r,
                                    st_nxt == efs_pkg::ST_LATCH && st_r != efs_pkg::ST_LATCH};
  wire [efs_pkg::IRQ_W-1:0] clr_w = (wr_en && a_icl) ? pwdata_i[efs_pkg::IRQ_W-1:0] : '0;
  wire [efs_pkg::IRQ_W-1:0] irq_sts_nxt = (irq_sts_r & ~clr_w) | evt;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl_r <= {31'h0, efs_pkg::CTRL_EN_RST};
      blank_r <= CW'(efs_pkg::BLANK_RST);
      retry_r <= CW'(efs_pkg::RETRY_RST);
      pga_r <= CW'(efs_pkg::PGA_RST);
      pgd_r <= CW'(efs_pkg::PGD_RST);
      irq_en_r <= '0;
    end else if (wr_en && !bad_acc) begin
      if (a_ctrl) ctrl_r <= {31'h0, pwdata_i[efs_pkg::CTRL_EN_BIT]};
      if (a_blank) blank_r <= pwdata_i[CW-1:0];
      if (a_retry) retry_r <= pwdata_i[CW-1:0];
      if (a_pga) pga_r <= pwdata_i[CW-1:0];
      if (a_pgd) pgd_r <= pwdata_i[CW-1:0];
      if (a_ien) irq_en_r <= pwdata_i[efs_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && bad_acc;
      prdata_o <= (setup && !pwrite_i) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st_r <= efs_pkg::ST_OFF;
      thermal_r <= 1'b0;
      flag_r <= 1'b0;
      pg_r <= 1'b0;
      sg_r <= 1'b0;
      irq_sts_r <= '0;
    end else begin
      st_r <= st_nxt;
      thermal_r <= thermal_nxt;
      flag_r <= flag_nxt;
      pg_r <= pg_nxt;
      sg_r <= sg_nxt;
      irq_sts_r <= irq_sts_nxt;
    end
  end

  // Pin drivers: only the pins of the chosen variant are ever pulled low
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      power_switch_on_o <= 1'b0;
      current_limit_o <= 1'b0;
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe_o <= 1'b0;
      power_good_out_o <= 1'b0;
      power_good_out_oe_o <= 1'b0;
      supply_valid_out_o <= 1'b0;
      supply_valid_out_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      power_switch_on_o <= (st_nxt == efs_pkg::ST_INRUSH) || (st_nxt == efs_pkg::ST_ON);
      current_limit_o <= climit_nxt;
      fault_flag_n_o <= !flag_nxt;
      fault_flag_n_oe_o <= !PG_VARIANT && flag_nxt;
      power_good_out_o <= pg_nxt;
      power_good_out_oe_o <= PG_VARIANT && !pg_nxt;
      supply_valid_out_o <= sg_nxt;
      supply_valid_out_oe_o <= !PG_VARIANT && !sg_nxt;
      irq_o <= |(irq_sts_nxt & irq_en_r);
    end
  end

  // Checks
  latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_r == efs_pkg::ST_LATCH && !clr_evt && (!AUTO_RETRY || thermal_r && hot)) |=> st_r == efs_pkg::ST_LATCH)
    else $error("latched fault left without a clearing event");
  latch_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (latched && clr_evt) |=> st_r == efs_pkg::ST_OFF)
    else $error("clearing event did not release latched fault");
  retry_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_r == efs_pkg::ST_RETRY && clr_evt) |-> !d_trig[D_RETRY])
    else $error("retry timer kept running through a clearing event");
  retry_restart_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_r == efs_pkg::ST_RETRY && d_done[D_RETRY]) |=> st_r == efs_pkg::ST_OFF)
    else $error("retry expiry did not restart the power path");
  trip_resume_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_r == efs_pkg::ST_TRIP && !hot) |-> !power_switch_on_o ##1 (st_r != efs_pkg::ST_LATCH))
    else $error("fast trip latched or kept the switch on");
  oc_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (!PG_VARIANT && d_done[D_OC]) |=> (fault_flag_n_oe_o && !fault_flag_n_o && st_r != efs_pkg::ST_LATCH))
    else $error("blanked overcurrent did not pull the fault flag");
  pg_rise_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(pg_r) |-> $past(d_done[D_PGA]) && $past(s_in[efs_pkg::IN_PGR]))
    else $error("power-good rose without its deglitch");
  pg_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(pg_r) |-> $past(d_done[D_PGD]) || $past(pg_hard))
    else $error("power-good fell without its deglitch");
  sg_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (sg_r && supply_ok) |=> sg_r)
    else $error("supply-good dropped on a valid supply");
  sg_rise_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(sg_r) |-> $past(st_r) == efs_pkg::ST_INRUSH && $past(s_in[efs_pkg::IN_GATE]))
    else $error("supply-good rose outside end of inrush");

  trip_cycle_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_r == efs_pkg::ST_TRIP ##1 st_r == efs_pkg::ST_ON);
  retry_cycle_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_r == efs_pkg::ST_RETRY ##1 st_r == efs_pkg::ST_OFF ##1 st_r == efs_pkg::ST_INRUSH);
  pg_assert_c: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(pg_r));
endmodule : efs_fault_status

/* dv/efs_pin_host.sv */
// Host side of the open-drain status pins, each with a pull-up resistor
module efs_pin_host (
  // Pin drivers of the device
  input wire logic flt_o_i,
  input wire logic flt_oe_i,
  input wire logic pg_o_i,
  input wire logic pg_oe_i,
  input wire logic sg_o_i,
  input wire logic sg_oe_i,
  // Resolved wire levels
  output logic flt_lvl_o,
  output logic pg_lvl_o,
  output logic sg_lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released pin reads the pull-up, never the last driven value
  assign flt_lvl_o = flt_oe_i ? flt_o_i : 1'b1;
  assign pg_lvl_o = pg_oe_i ? pg_o_i : 1'b1;
  assign sg_lvl_o = sg_oe_i ? sg_o_i : 1'b1;
endmodule : efs_pin_host

/* dv/testbench.sv */
// Register-level test of the fault and status logic through APB
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, er;
  logic vin = 1'b1, enuv = 1'b1, ensd = 1'b1, ovl = 1'b0, oc = 1'b0;
  logic ft = 1'b0, hot = 1'b0, cool = 1'b0, gate = 1'b0;
  logic ilmo = 1'b0, pgr = 1'b0, pgf = 1'b0;
  logic sw, cl, fo, foe, po, poe, so, soe, irq, fl, pl, sl;
  int n_errors = 0;
  int n_compared = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  efs_fault_status #(.AUTO_RETRY(1'b1), .PG_VARIANT(1'b0), .TRIP_CYC(20)) i_efs_fault_status (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .vin_present_i(vin), .enable_undervoltage_in_i(enuv), .enable_above_shutdown_i(ensd),
    .overvoltage_lockout_i(ovl), .overcurrent_i(oc), .fast_trip_i(ft),
    .current_sense_pin_open_i(ilmo), .current_sense_pin_short_i(1'b0),
    .thermal_shutdown_limit_i(hot), .thermal_cooled_i(cool),
    .good_threshold_sense_rise_i(pgr), .good_threshold_sense_fall_i(pgf),
    .gate_full_overdrive_i(gate), .power_switch_on_o(sw), .current_limit_o(cl),
    .fault_flag_n_i(fl), .fault_flag_n_o(fo), .fault_flag_n_oe_o(foe),
    .power_good_out_i(pl), .power_good_out_o(po), .power_good_out_oe_o(poe),
    .supply_valid_out_i(sl), .supply_valid_out_o(so), .supply_valid_out_oe_o(soe), .irq_o(irq));
  efs_pin_host i_efs_pin_host (
    .flt_o_i(fo), .flt_oe_i(foe), .pg_o_i(po), .pg_oe_i(poe), .sg_o_i(so), .sg_oe_i(soe),
    .flt_lvl_o(fl), .pg_lvl_o(pl), .sg_lvl_o(sl));
  task report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One transfer; read data and error are taken at the edge that sees pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk_i);
      if (prdy === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      report_and_stop();
    end
    rd = prd;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : xfer
  // Poll the state field; a bounded number of reads
  task wait_state(input logic [2:0] s);
    int k;
    for (k = 0; k < 100; k++) begin
      xfer(1'b0, efs_pkg::ADDR_STATUS, 32'h0);
      if (rd[2:0] === s) break;
    end
    check({29'h0, rd[2:0]}, {29'h0, s});
    if (k == 100) report_and_stop();
  endtask : wait_state
  task idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  initial begin
    idle(6);
    rstn_i <= 1'b1;
    xfer(1'b0, efs_pkg::ADDR_CTRL, 32'h0); check(rd, 32'h1);
    xfer(1'b0, efs_pkg::ADDR_BLANK, 32'h0); check(rd, 32'h100);
    xfer(1'b0, efs_pkg::ADDR_RETRY, 32'h0); check(rd, 32'h400);
    xfer(1'b0, efs_pkg::ADDR_PGD, 32'h0); check(rd, 32'h40);
    xfer(1'b0, efs_pkg::ADDR_PGA, 32'h0); check(rd, 32'h80);
    xfer(1'b0, 8'h40, 32'h0); check({31'h0, er}, 32'h1);
    xfer(1'b1, efs_pkg::ADDR_STATUS, 32'h0); check({31'h0, er}, 32'h1);
    xfer(1'b0, efs_pkg::ADDR_IRQ_CLR, 32'h0); check(rd, 32'h0);
    xfer(1'b1, efs_pkg::ADDR_BLANK, 32'h8);
    xfer(1'b1, efs_pkg::ADDR_RETRY, 32'h10);
    xfer(1'b1, efs_pkg::ADDR_PGA, 32'h8);
    xfer(1'b1, efs_pkg::ADDR_PGD, 32'h8);
    xfer(1'b1, efs_pkg::ADDR_IRQ_EN, 32'h1);
    wait_state(3'd1);
    check({31'h0, rd[7]}, 32'h0);
    check({31'h0, sl}, 32'h0);
    pgr <= 1'b1;
    gate <= 1'b1;
    wait_state(3'd2);
    idle(2);
    check({31'h0, sl}, 32'h1);
    // Persistent overcurrent: limit at once, flag only after blanking
    oc <= 1'b1;
    idle(6);
    check({30'h0, cl, fl}, 32'h3);
    idle(12);
    check({30'h0, cl, fl}, 32'h2);
    check({31'h0, sl}, 32'h1);
    xfer(1'b0, efs_pkg::ADDR_STATUS, 32'h0); check({29'h0, rd[2:0]}, 32'h2);
    check({31'h0, rd[7]}, 32'h1);
    oc <= 1'b0;
    idle(8);
    check({31'h0, fl}, 32'h1);
    // Output short: fast trip, no flag, back on
    ft <= 1'b1;
    idle(1);
    ft <= 1'b0;
    wait_state(3'd3);
    check({29'h0, fl, sl, sw}, 32'h6);
    check({31'h0, rd[7]}, 32'h1);
    wait_state(3'd2);
    xfer(1'b0, efs_pkg::ADDR_IRQ_STS, 32'h0); check({31'h0, rd[4]}, 32'h1);
    check({31'h0, sw}, 32'h1);
    // Sense below its falling threshold drops power-good after the deassert deglitch
    pgr <= 1'b0;
    pgf <= 1'b1;
    idle(20);
    xfer(1'b0, efs_pkg::ADDR_STATUS, 32'h0); check({31'h0, rd[7]}, 32'h0);
    check({31'h0, pl}, 32'h1);
    // Open sense pin: shutdown with the fault flag, restart once it is gone
    ilmo <= 1'b1;
    wait_state(3'd0);
    check({30'h0, fl, sw}, 32'h0);
    ilmo <= 1'b0;
    wait_state(3'd2);
    // Thermal latch: small enable dip ignored, shutdown threshold clears
    hot <= 1'b1;
    wait_state(3'd4);
    idle(2);
    check({30'h0, fl, irq}, 32'h1);
    check({31'h0, sl}, 32'h1);
    enuv <= 1'b0;
    hot <= 1'b0;
    idle(30);
    enuv <= 1'b1;
    wait_state(3'd4);
    xfer(1'b1, efs_pkg::ADDR_IRQ_CLR, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h0);
    // The shutdown threshold lies below the undervoltage one, so both fall together
    ensd <= 1'b0;
    enuv <= 1'b0;
    wait_state(3'd0);
    ensd <= 1'b1;
    enuv <= 1'b1;
    cool <= 1'b1;
    wait_state(3'd2);
    // Auto-retry after cooling
    hot <= 1'b1;
    cool <= 1'b0;
    wait_state(3'd4);
    hot <= 1'b0;
    cool <= 1'b1;
    wait_state(3'd5);
    wait_state(3'd2);
    // Supply loss drops supply-good; the enable dips set the same event, so clear it first
    xfer(1'b1, efs_pkg::ADDR_IRQ_CLR, 32'h8);
    xfer(1'b0, efs_pkg::ADDR_IRQ_STS, 32'h0); check({31'h0, rd[3]}, 32'h0);
    vin <= 1'b0;
    wait_state(3'd0);
    idle(2);
    check({30'h0, sl, sw}, 32'h0);
    xfer(1'b0, efs_pkg::ADDR_IRQ_STS, 32'h0); check({31'h0, rd[3]}, 32'h1);
    report_and_stop();
  end
endmodule : testbench
